// ### hdl/pmw_params.svh
`ifndef PMW_PARAMS_SVH
`define PMW_PARAMS_SVH
// ----------------------------------------
// register map (word index on the plain port)
// ----------------------------------------
`define PMW_ADDR_W 4
`define PMW_A_MODE 4'h0
`define PMW_A_DSCTL 4'h1
`define PMW_A_WAKE 4'h2
`define PMW_A_GPRA 4'h3
`define PMW_A_GPRB 4'h4
`define PMW_A_STAT 4'h5
// ----------------------------------------
// field positions
// ----------------------------------------
`define PMW_MODE_IDLE 0
`define PMW_MODE_SCS_LO 1
`define PMW_MODE_SCS_HI 2
`define PMW_MODE_REGULATOR_SLEEP_BIT 3
`define PMW_DS_ARM 0
`define PMW_DS_RELEASE 1
`define PMW_DS_EXIT 2
// ----------------------------------------
// timing
// ----------------------------------------
`define PMW_CPU_READY_NS 200
`define PMW_CLK_NS 10
`define PMW_CPU_READY_CYC ((`PMW_CPU_READY_NS + `PMW_CLK_NS - 1) / `PMW_CLK_NS)
`define PMW_OST_CYC 16
`define PMW_ARM_LIFE 2'h2
`define PMW_NPINS 8
`define PMW_NWAKE 6
`endif

// ### hdl/pmw_pkg.sv
package pmw_pkg;
    typedef enum logic [2:0] {
        PMW_RUN,
        PMW_IDLE,
        PMW_SLEEP,
        PMW_OST,
        PMW_READY,
        PMW_DEEP
    } pmw_state_e;
    typedef struct packed {
        logic sleep;
        logic clear_watchdog_instr;
        logic nop;
    } pmw_instr_s;
    typedef struct packed {
        logic master_clear_reset;
        logic rtc_alarm;
        logic ext_irq0;
        logic ulp_wake;
        logic ds_wdt;
        logic fault;
    } pmw_wake_s;
    typedef struct packed {
        logic [7:0] dir;
        logic [7:0] lat;
    } pmw_pins_s;
endpackage

// ### hdl/pmw_sequencer.sv
// Strobed register access and the address map were decided locally.
`timescale 1ns/100ps
`include "pmw_params.svh"
// Function
// - idle sleep from internal run enters idle
// - internal idle wake keeps clock, ready delay
// - low freq osc runs if watchdog/monitor on
// - exit only by irq, reset, watchdog
// - enabled irq flag starts exit
// - vector if global enable, else continue
// - cpu ready delay before execution restarts
// - watchdog wakes when idle, resets when running
// - clear watchdog on sleep/clear/clock loss
// - reset exit runs from low freq osc
// - external clock idle skips start-up timer
// - arm bit self-clears after two cycles
// - deep entry clears wake log
// - deep wake forces power-on reset
// - retained data survive deep sleep
// - pins hold state in deep sleep
// - pins held until release cleared
// - brownout drops all, clear releases pins
// - exit flag sticky until software clears
// - wake captured only when fully deep
// - only first wake source logged
module pmw_sequencer (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic [`PMW_ADDR_W-1:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out,
    input wire pmw_pkg::pmw_instr_s instr_in,
    input wire logic irq_flag_in,
    input wire logic irq_en_in,
    input wire logic gie_in,
    input wire logic wdt_timeout_in,
    input wire logic wdt_en_in,
    input wire logic failsafe_clock_monitor_en_in,
    input wire logic clk_lost_in,
    input wire logic ext_clk_mode_in,
    input wire pmw_pkg::pmw_wake_s wake_pin_in,
    input wire logic ds_brownout_in,
    input wire pmw_pkg::pmw_pins_s pins_cfg_in,
    output logic cpu_run_out,
    output logic periph_clk_en_out,
    output logic prim_osc_en_out,
    output logic lf_osc_en_out,
    output logic osc_startup_status_out,
    output logic wdt_clear_out,
    output logic wdt_reset_out,
    output logic por_out,
    output logic vector_out,
    output logic rtc_run_out,
    output logic [`PMW_NPINS-1:0] pin_oe_out,
    output logic [`PMW_NPINS-1:0] pin_o_out
);
    import pmw_pkg::*;

    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    logic [`PMW_NWAKE-1:0] wake_m_r, wake_s_r;
    logic bo_m_r, bo_s_r;
    always_ff @(posedge clock_in) begin
        wake_m_r <= wake_pin_in;
        wake_s_r <= wake_m_r;
        bo_m_r <= ds_brownout_in;
        bo_s_r <= bo_m_r;
    end
    pmw_wake_s wake_s;
    assign wake_s = wake_s_r;

    // ----------------------------------------
    // registers
    // ----------------------------------------
    pmw_state_e state_r;
    logic idle_sel_r;
    logic [1:0] scs_r;
    logic regulator_sleep_bit_r;
    logic arm_r;
    logic [1:0] arm_age_r;
    logic release_r;
    logic exit_flag_r;
    logic [`PMW_NWAKE-1:0] wake_log_r;
    logic [7:0] gpr_a_r, gpr_b_r;
    logic [7:0] cnt_r;
    logic ext_clk_r;
    pmw_pins_s held_r;
    logic deep_wake;
    logic wake_ev;
    assign deep_wake = state_r == PMW_DEEP && (|wake_s_r);
    assign wake_ev = (irq_flag_in && irq_en_in) || wdt_timeout_in;

    // ----------------------------------------
    // deep-sleep entry decode
    // ----------------------------------------
    // one decode shared by state, log and pin latch, so they can never disagree
    function automatic logic deep_go(input pmw_state_e st, input logic slp, input logic arm, input logic reg_slp,
                                     input logic idle, input logic gie);
        deep_go = st == PMW_RUN && slp && arm && reg_slp && !idle && !gie;
    endfunction
    logic deep_enter;
    assign deep_enter = deep_go(state_r, instr_in.sleep, arm_r, regulator_sleep_bit_r, idle_sel_r, gie_in);

    logic wr_mode, wr_ds;
    assign wr_mode = wr_in && addr_in == `PMW_A_MODE;
    assign wr_ds = wr_in && addr_in == `PMW_A_DSCTL;

    // mode bits are untouched by any wake
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            idle_sel_r <= 1'b0;
            scs_r <= 2'h0;
            regulator_sleep_bit_r <= 1'b0;
        end else if (wr_mode && state_r == PMW_RUN) begin
            idle_sel_r <= wdata_in[`PMW_MODE_IDLE];
            scs_r <= wdata_in[`PMW_MODE_SCS_HI:`PMW_MODE_SCS_LO];
            regulator_sleep_bit_r <= wdata_in[`PMW_MODE_REGULATOR_SLEEP_BIT];
        end
    end

    // arm bit lives two instruction cycles only
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            arm_r <= 1'b0;
            arm_age_r <= 2'h0;
        end else if (wr_ds && wdata_in[`PMW_DS_ARM]) begin
            arm_r <= 1'b1;
            arm_age_r <= 2'h0;
        end else if (arm_r) begin
            arm_age_r <= arm_age_r + 2'h1;
            if (arm_age_r + 2'h1 == `PMW_ARM_LIFE) arm_r <= 1'b0;
        end
    end

    // ----------------------------------------
    // power-mode sequencer
    // ----------------------------------------
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            state_r <= PMW_RUN;
            cnt_r <= 8'h0;
            ext_clk_r <= 1'b0;
        end else begin
            unique case (state_r)
                PMW_RUN: begin
                    ext_clk_r <= ext_clk_mode_in;
                    if (instr_in.sleep) begin
                        if (deep_enter) state_r <= PMW_DEEP;
                        else if (idle_sel_r) state_r <= PMW_IDLE;
                        else state_r <= PMW_SLEEP;
                    end
                end
                PMW_IDLE: begin
                    if (wake_ev) begin
                        state_r <= PMW_READY;
                        cnt_r <= 8'(`PMW_CPU_READY_CYC);
                    end
                end
                PMW_SLEEP: begin
                    if (wake_ev) begin
                        state_r <= PMW_OST;
                        cnt_r <= 8'(`PMW_OST_CYC);
                    end
                end
                PMW_OST: begin
                    cnt_r <= cnt_r - 8'h1;
                    if (cnt_r == 8'h1) begin
                        state_r <= PMW_READY;
                        cnt_r <= 8'(`PMW_CPU_READY_CYC);
                    end
                end
                PMW_READY: begin
                    cnt_r <= cnt_r - 8'h1;
                    if (cnt_r == 8'h1) state_r <= PMW_RUN;
                end
                PMW_DEEP: begin
                    if (deep_wake || bo_s_r) state_r <= PMW_RUN;
                end
            endcase
        end
    end

    // first source wins, cleared on deep entry
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            wake_log_r <= '0;
        end else if (deep_enter) begin
            wake_log_r <= '0;
        end else if (deep_wake && wake_log_r == '0) begin
            wake_log_r <= wake_s_r;
        end
    end

    // exit flag: set beats clear
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) exit_flag_r <= 1'b0;
        else if (deep_wake) exit_flag_r <= 1'b1;
        else if (wr_ds && !wdata_in[`PMW_DS_EXIT]) exit_flag_r <= 1'b0;
    end

    // retained data: brown-out is the only loss
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            gpr_a_r <= 8'h0;
            gpr_b_r <= 8'h0;
        end else if (state_r == PMW_DEEP && bo_s_r) begin
            gpr_a_r <= 8'h0;
            gpr_b_r <= 8'h0;
        end else if (wr_in && addr_in == `PMW_A_GPRA) begin
            gpr_a_r <= wdata_in;
        end else if (wr_in && addr_in == `PMW_A_GPRB) begin
            gpr_b_r <= wdata_in;
        end
    end

    // pin hold latch
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            release_r <= 1'b0;
            held_r <= '0;
        end else if (deep_enter) begin
            release_r <= 1'b1;
            held_r <= pins_cfg_in;
        end else if (state_r == PMW_DEEP && (bo_s_r || wake_s.master_clear_reset)) begin
            release_r <= 1'b0;
        end else if (wr_ds && !wdata_in[`PMW_DS_RELEASE]) begin
            release_r <= 1'b0;
        end
    end

    // ----------------------------------------
    // registered outputs
    // ----------------------------------------
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            cpu_run_out <= 1'b0;
            periph_clk_en_out <= 1'b1;
            prim_osc_en_out <= 1'b0;
            lf_osc_en_out <= 1'b1;
            osc_startup_status_out <= 1'b0;
            wdt_clear_out <= 1'b0;
            wdt_reset_out <= 1'b0;
            por_out <= 1'b0;
            vector_out <= 1'b0;
            rtc_run_out <= 1'b1;
            pin_oe_out <= '0;
            pin_o_out <= '0;
            rdata_out <= 8'h0;
        end else begin
            cpu_run_out <= state_r == PMW_RUN;
            periph_clk_en_out <= state_r != PMW_SLEEP && state_r != PMW_DEEP;
            // internal osc modes shut the primary down
            prim_osc_en_out <= scs_r == 2'h0 && state_r != PMW_SLEEP && state_r != PMW_DEEP;
            lf_osc_en_out <= wdt_en_in || failsafe_clock_monitor_en_in || state_r == PMW_RUN || scs_r == 2'h3;
            osc_startup_status_out <= scs_r == 2'h0 && (state_r == PMW_RUN || state_r == PMW_IDLE);
            wdt_clear_out <= instr_in.sleep || instr_in.clear_watchdog_instr || (clk_lost_in && failsafe_clock_monitor_en_in);
            wdt_reset_out <= wdt_timeout_in && state_r == PMW_RUN;
            por_out <= state_r == PMW_DEEP && (deep_wake || bo_s_r);
            vector_out <= state_r == PMW_READY && cnt_r == 8'h1 && gie_in && irq_flag_in;
            rtc_run_out <= 1'b1;
            for (int i = 0; i < `PMW_NPINS; i++) begin
                pin_oe_out[i] <= release_r ? !held_r.dir[i] : !pins_cfg_in.dir[i];
                pin_o_out[i] <= release_r ? held_r.lat[i] : pins_cfg_in.lat[i];
            end
            if (!rd_in) rdata_out <= 8'h0;
            else begin
                unique case (addr_in)
                    `PMW_A_MODE: rdata_out <= {4'h0, regulator_sleep_bit_r, scs_r, idle_sel_r};
                    `PMW_A_DSCTL: rdata_out <= {5'h0, exit_flag_r, release_r, arm_r};
                    `PMW_A_WAKE: rdata_out <= {2'h0, wake_log_r};
                    `PMW_A_GPRA: rdata_out <= gpr_a_r;
                    `PMW_A_GPRB: rdata_out <= gpr_b_r;
                    `PMW_A_STAT: rdata_out <= {5'h0, 3'(state_r)};
                    default: rdata_out <= 8'h0;
                endcase
            end
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_arm_self_clear: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        $rose(arm_r) |-> ##2 !arm_r) else $error("arm bit did not self clear");
    a_wdt_run_reset: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (wdt_timeout_in && state_r == PMW_RUN) |=> wdt_reset_out) else $error("no watchdog reset");
    a_exit_sticky: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (exit_flag_r && !wr_ds) |=> exit_flag_r) else $error("exit flag dropped");
    a_idle_entry: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (state_r == PMW_RUN && instr_in.sleep && idle_sel_r) |=> state_r == PMW_IDLE) else $error("no idle");
    a_ready_delay: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (state_r == PMW_IDLE && wake_ev) |=> state_r == PMW_READY ##19 state_r == PMW_READY ##1 state_r == PMW_RUN)
        else $error("ready delay wrong");
    a_deep_entry: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        deep_enter |=> state_r == PMW_DEEP) else $error("no deep entry");
    a_log_cleared: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        deep_enter |=> wake_log_r == '0) else $error("wake log not cleared");
    a_pins_held: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        deep_enter |=> release_r && held_r == $past(pins_cfg_in)) else $error("pins not captured");
    a_sleep_ost: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (state_r == PMW_SLEEP && wake_ev) |=> state_r == PMW_OST) else $error("no start-up wait");
    a_deep_stay: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (state_r == PMW_DEEP && !deep_wake && !bo_s_r) |=> state_r == PMW_DEEP) else $error("deep left early");
    a_rtc_runs: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        state_r == PMW_DEEP |=> rtc_run_out) else $error("rtc stopped");
    a_gpr_kept: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (state_r == PMW_DEEP && !bo_s_r) |=> $stable(gpr_a_r) && $stable(gpr_b_r)) else $error("gpr lost");
    c_deep_entry: cover property (@(posedge clock_in) disable iff (!rst_n_in) deep_enter);
    a_stay_asleep: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (state_r == PMW_SLEEP && !wake_ev) |=> state_r == PMW_SLEEP) else $error("spurious wake");
    a_deep_por: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        deep_wake |=> por_out && state_r == PMW_RUN) else $error("no por on deep wake");
    a_log_first: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (wake_log_r != '0 && state_r != PMW_RUN) |=> $stable(wake_log_r)) else $error("log overwritten");
    a_wdt_clear: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        instr_in.clear_watchdog_instr |=> wdt_clear_out) else $error("watchdog not cleared");
    c_deep: cover property (@(posedge clock_in) disable iff (!rst_n_in) deep_wake);
    c_idle_wake: cover property (@(posedge clock_in) disable iff (!rst_n_in) state_r == PMW_IDLE && wake_ev);
    c_sleep_ost: cover property (@(posedge clock_in) disable iff (!rst_n_in) state_r == PMW_OST);
endmodule

// ### tb/pmw_cpu_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// cpu instruction stream
// ----------------------------------------
module pmw_cpu_model (
    input wire logic clock_in,
    input wire logic cpu_run_in,
    input wire logic [1:0] cmd_in,
    output pmw_pkg::pmw_instr_s instr_out
);
    import pmw_pkg::*;
    // cmd 1 sleep, 2 nop then sleep, 3 clear watchdog
    logic sleep_next_r = 1'b0;
    initial instr_out = '0;
    // a halted cpu issues nothing, so no instruction leaks into a sleep
    always @(posedge clock_in) begin
        instr_out.sleep <= cpu_run_in && (sleep_next_r || cmd_in == 2'h1);
        instr_out.nop <= cpu_run_in && cmd_in == 2'h2;
        instr_out.clear_watchdog_instr <= cpu_run_in && cmd_in == 2'h3;
        sleep_next_r <= cpu_run_in && cmd_in == 2'h2;
    end
endmodule

// ### tb/testbench.sv
`timescale 1ns/100ps
`include "pmw_params.svh"
module testbench;
    import pmw_pkg::*;
    // ----------------------------------------
    // stimulus and design
    // ----------------------------------------
    logic clock_in = 1'b0, rst_n_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0;
    logic irq_flag_in = 1'b0, irq_en_in = 1'b0, gie_in = 1'b0, wdt_timeout_in = 1'b0, wdt_en_in = 1'b0;
    logic failsafe_clock_monitor_en_in = 1'b0, clk_lost_in = 1'b0, ext_clk_mode_in = 1'b0, ds_brownout_in = 1'b0;
    logic [`PMW_ADDR_W-1:0] addr_in = 4'h0;
    logic [7:0] wdata_in = 8'h00, rdata_out, pin_oe_out, pin_o_out;
    logic [1:0] cmd_r = 2'h0;
    logic cpu_run_out, periph_clk_en_out, prim_osc_en_out, lf_osc_en_out, osc_startup_status_out;
    logic wdt_clear_out, wdt_reset_out, por_out, vector_out, rtc_run_out;
    pmw_instr_s instr_in;
    pmw_wake_s wake_pin_in = '0;
    pmw_pins_s pins_cfg_in = '0;
    int error_cnt = 0, total_checks = 0, vec_n = 0, por_n = 0, wclr_n = 0, wrst_n = 0;
    pmw_sequencer pmw_sequencer_i (.clock_in, .rst_n_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
        .instr_in, .irq_flag_in, .irq_en_in, .gie_in, .wdt_timeout_in, .wdt_en_in, .failsafe_clock_monitor_en_in, .clk_lost_in,
        .ext_clk_mode_in, .wake_pin_in, .ds_brownout_in, .pins_cfg_in, .cpu_run_out, .periph_clk_en_out,
        .prim_osc_en_out, .lf_osc_en_out, .osc_startup_status_out, .wdt_clear_out, .wdt_reset_out, .por_out,
        .vector_out, .rtc_run_out, .pin_oe_out, .pin_o_out);
    pmw_cpu_model pmw_cpu_model_i (.clock_in, .cpu_run_in(cpu_run_out), .cmd_in(cmd_r), .instr_out(instr_in));
    initial begin
        forever #5 clock_in = ~clock_in;
    end
    // pulses are tallied so scenarios compare counts, not exact cycles
    always @(posedge clock_in) begin
        vec_n += int'(vector_out === 1'b1);
        por_n += int'(por_out === 1'b1);
        wclr_n += int'(wdt_clear_out === 1'b1);
        wrst_n += int'(wdt_reset_out === 1'b1);
    end
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // w=1 writes d, w=0 reads and compares the masked word with d
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d, input logic [7:0] m);
        @(posedge clock_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= w;
        rd_in <= !w;
        @(posedge clock_in);
        wr_in <= 1'b0;
        rd_in <= 1'b0;
        #1;
        if (!w)
            check(rdata_out & m, d);
    endtask
    task automatic cmd(input logic [1:0] c);
        @(posedge clock_in);
        cmd_r <= c;
        @(posedge clock_in);
        cmd_r <= 2'h0;
    endtask
    task automatic wait_run(input int lo, input int hi);
        int n;
        n = 0;
        while (cpu_run_out !== 1'b1 && n < 300) begin
            @(posedge clock_in);
            #1;
            n++;
        end
        check(8'(n >= lo && n <= hi), 8'h01);
        if (n >= 300)
            wrap_up();
    endtask
    task automatic deep_entry();
        @(posedge clock_in);
        addr_in <= `PMW_A_DSCTL;
        wdata_in <= 8'h01;
        wr_in <= 1'b1;
        cmd_r <= 2'h2;
        @(posedge clock_in);
        wr_in <= 1'b0;
        cmd_r <= 2'h0;
        repeat (4) @(posedge clock_in);
        bus(1'b0, `PMW_A_STAT, 8'h05, 8'hff);
        bus(1'b0, `PMW_A_WAKE, 8'h00, 8'hff);
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_run();
        int r0, c0;
        r0 = wrst_n;
        c0 = wclr_n;
        @(posedge clock_in);
        wdt_timeout_in <= 1'b1;
        failsafe_clock_monitor_en_in <= 1'b1;
        clk_lost_in <= 1'b1;
        @(posedge clock_in);
        wdt_timeout_in <= 1'b0;
        clk_lost_in <= 1'b0;
        cmd(2'h3);
        repeat (4) @(posedge clock_in);
        #1;
        check(8'(wrst_n - r0), 8'h01);
        check(8'(wclr_n - c0), 8'h02);
    endtask
    task automatic t_idle();
        int v0, c0;
        bus(1'b1, `PMW_A_MODE, 8'h07, 8'h00);
        @(posedge clock_in);
        wdt_en_in <= 1'b1;
        ext_clk_mode_in <= 1'b1;
        irq_en_in <= 1'b1;
        gie_in <= 1'b1;
        c0 = wclr_n;
        cmd(2'h1);
        repeat (3) @(posedge clock_in);
        #1;
        check({prim_osc_en_out, osc_startup_status_out, periph_clk_en_out}, 8'h01);
        check(8'(lf_osc_en_out), 8'h01);
        check(8'(wclr_n - c0), 8'h01);
        bus(1'b0, `PMW_A_STAT, 8'h01, 8'hff);
        v0 = vec_n;
        @(posedge clock_in);
        irq_flag_in <= 1'b1;
        #1;
        wait_run(20, 25);
        @(posedge clock_in);
        irq_flag_in <= 1'b0;
        check(8'(vec_n - v0), 8'h01);
        bus(1'b0, `PMW_A_MODE, 8'h07, 8'hff);
    endtask
    task automatic t_sleep();
        int v0, r0;
        bus(1'b1, `PMW_A_MODE, 8'h08, 8'h00);
        @(posedge clock_in);
        gie_in <= 1'b0;
        irq_en_in <= 1'b0;
        bus(1'b1, `PMW_A_DSCTL, 8'h01, 8'h00);
        cmd(2'h1);
        @(posedge clock_in);
        irq_flag_in <= 1'b1;
        repeat (30) @(posedge clock_in);
        bus(1'b0, `PMW_A_STAT, 8'h02, 8'hff);
        v0 = vec_n;
        r0 = wrst_n;
        @(posedge clock_in);
        irq_flag_in <= 1'b0;
        wdt_timeout_in <= 1'b1;
        @(posedge clock_in);
        wdt_timeout_in <= 1'b0;
        #1;
        wait_run(35, 41);
        check(8'(vec_n - v0 + wrst_n - r0), 8'h00);
    endtask
    task automatic t_deep_rtc();
        int p0;
        bus(1'b1, `PMW_A_GPRA, 8'h5a, 8'h00);
        bus(1'b1, `PMW_A_GPRB, 8'hc3, 8'h00);
        @(posedge clock_in);
        pins_cfg_in <= {8'h0f, 8'ha5};
        deep_entry();
        @(posedge clock_in);
        pins_cfg_in <= {8'hff, 8'h00};
        repeat (2) @(posedge clock_in);
        #1;
        check(pin_oe_out, 8'hf0);
        check(pin_o_out & 8'hf0, 8'ha0);
        check(8'(rtc_run_out), 8'h01);
        p0 = por_n;
        @(posedge clock_in);
        wake_pin_in.rtc_alarm <= 1'b1;
        @(posedge clock_in);
        wake_pin_in.ext_irq0 <= 1'b1;
        #1;
        wait_run(1, 10);
        @(posedge clock_in);
        wake_pin_in <= '0;
        #1;
        check(8'(por_n - p0), 8'h01);
        check(pin_oe_out, 8'hf0);
        bus(1'b0, `PMW_A_DSCTL, 8'h04, 8'h04);
        bus(1'b0, `PMW_A_WAKE, 8'h10, 8'hff);
        bus(1'b0, `PMW_A_GPRA, 8'h5a, 8'hff);
        bus(1'b0, `PMW_A_GPRB, 8'hc3, 8'hff);
        bus(1'b1, `PMW_A_DSCTL, 8'h00, 8'h00);
        bus(1'b0, `PMW_A_DSCTL, 8'h00, 8'h04);
        check(pin_oe_out, 8'h00);
    endtask
    task automatic t_deep_master_clear_reset();
        bus(1'b1, `PMW_A_MODE, 8'h08, 8'h00);
        @(posedge clock_in);
        pins_cfg_in <= {8'h0f, 8'h3c};
        deep_entry();
        @(posedge clock_in);
        pins_cfg_in <= {8'hf0, 8'h81};
        wake_pin_in.master_clear_reset <= 1'b1;
        #1;
        wait_run(1, 10);
        @(posedge clock_in);
        wake_pin_in <= '0;
        bus(1'b0, `PMW_A_WAKE, 8'h20, 8'hff);
        bus(1'b0, `PMW_A_GPRA, 8'h5a, 8'hff);
        check(pin_oe_out, 8'h0f);
        check(pin_o_out & 8'h0f, 8'h01);
    endtask
    initial begin
        repeat (11) @(posedge clock_in);
        #1;
        check({lf_osc_en_out, cpu_run_out, rtc_run_out}, 8'h05);
        @(posedge clock_in);
        rst_n_in <= 1'b1;
        repeat (3) @(posedge clock_in);
        t_run();
        t_idle();
        t_sleep();
        t_deep_rtc();
        t_deep_master_clear_reset();
        wrap_up();
    end
    initial begin
        repeat (20000) @(posedge clock_in);
        error_cnt++;
        wrap_up();
    end
endmodule
